// File: design/tsc_pkg.sv
package tsc_pkg;
   // Register numbers of the processor-status space
   localparam logic [7:0] REG_BOOT_REPORT  = 8'h03;
   localparam logic [7:0] REG_SECURITY     = 8'h05;
   localparam logic [7:0] REG_RING_CONTROL = 8'h06;
   localparam logic [7:0] REG_RING_FIRST   = 8'h07;
   localparam logic [7:0] REG_RING_LAST    = 8'h0A;
   localparam logic [7:0] REG_MEMORY_SIZE  = 8'h0C;
   localparam logic [7:0] REG_DEBUG_STATUS = 8'h10;
   localparam logic [7:0] REG_DEBUG_PC     = 8'h11;

   // Field positions
   localparam int BOOT_PROC_LSB    = 16;
   localparam int BOOT_OVERRIDE    = 8;
   localparam int BOOT_CORE_OFF    = 5;
   localparam int BOOT_NO_POLL     = 4;
   localparam int BOOT_FROM_RAM    = 3;
   localparam int BOOT_FROM_TAP    = 2;
   localparam int SEC_WRITE_LOCK   = 31;
   localparam int SEC_NO_GLOBAL_DBG = 14;
   localparam int SEC_LOCK_ALL     = 12;
   localparam int SEC_SECTOR_LSB   = 8;
   localparam int SEC_REDUNDANCY   = 7;
   localparam int SEC_OTP_BOOT     = 5;
   localparam int SEC_NO_CFG_SCAN  = 4;
   localparam int SEC_NO_DEBUG_TAP = 0;
   localparam int RING_CORE_EN     = 1;
   localparam int RING_PERIPH_EN   = 0;
   localparam int DSS_DUAL_ISSUE   = 8;

   // Writable and readable masks
   localparam logic [31:0] SEC_MASK        = 32'h8000_5FB1;
   localparam logic [31:0] RING_CTRL_MASK  = 32'h0000_0003;
   localparam logic [31:0] DSS_MASK        = 32'h0000_07DF;
   localparam logic [31:0] DSS_WRITE_MASK  = 32'h0000_06DF;
   localparam logic [31:0] MEM_SIZE_MASK   = 32'hFFFF_FFFC;

   // Values after reset; the count value applies at power-up only
   localparam logic [31:0] RING_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] DEBUG_RESET     = 32'h0000_0000;
   localparam logic [15:0] COUNT_INIT      = 16'h0000;

   // Core clock 10 MHz; counters must settle 10 core cycles after stop
   localparam int CLOCK_HZ          = 10_000_000;
   localparam int RING_SETTLE_CYCLES = 10;
   localparam int RING_COUNT        = 4;
endpackage

// File: design/tsc_status_regs.sv
`timescale 1ns/10ps
// Functional notes
// - Boot report is fully read-only; processor number in bits 23:16.
// - Boot report bits 1:0 show sampled PLL mode strap.
// - Boot bit 3 boot from RAM, bit 2 over TAP, bit 8 override.
// - Boot bit 5 second core powered off, bit 4 skip OTP level polling.
// - Security bit 31 set blocks further status writes to security register; an OTP load or a reset still replaces it.
// - Security bit 14 refuses the global debug facility.
// - Security bit 0 blocks debug TAP over boundary scan.
// - Bits 11:8 lock one OTP sector each, 12 all, 7 redundancy.
// - Security bit 5 ignores boot straps, boots image from OTP.
// - Security bit 4 denies scan access to PLL and boot registers.
// - Security register loads from its OTP copy.
// - Four free-running ring oscillators each clock own counter, gated by control.
// - Control bit 1 enables core rings, bit 0 peripheral; both reset zero.
// - 16-bit counts at 0x07..0x0A: tile cell, wire, periph cell, wire.
// - Ring counts survive system reset.
// - Ring oscillators run asynchronous to tile clock, giving random bits.
// - Read-only RAM size in bytes, bits 31:2.
// - Debug entry snapshots saved status; bits 10, 7, 6 as documented.
// - Snapshot bits 4 kernel, 3 interrupt, 2 event-enable, 1 ints, 0 events.
// - Status bit 9 selects kernel-entry dual issue; bit 8 read-only current.
// - Debug entry captures full 32-bit saved program counter.
// - Bank reached only by the tile processor's status instructions.
module tsc_status_regs (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   input  wire logic        ps_write,
   input  wire logic [7:0]  ps_number,
   input  wire logic [31:0] ps_wdata,
   output logic      [31:0] ps_rdata,
   output logic             ps_hit,
   input  wire logic        debug_mode,
   input  wire logic [7:0]  processor_number,
   input  wire logic [1:0]  pll_mode_strap,
   input  wire logic        boot_from_ram,
   input  wire logic        boot_from_tap,
   input  wire logic        boot_override,
   input  wire logic        second_core_off,
   input  wire logic        skip_otp_poll,
   input  wire logic        otp_load,
   input  wire logic [31:0] otp_security_copy,
   input  wire logic [31:0] ram_size_bytes,
   input  wire logic        debug_entry,
   input  wire logic [31:0] saved_status_word,
   input  wire logic [31:0] saved_program_counter,
   input  wire logic [3:0]  ring_clock,
   output logic [3:0]       ring_enable,
   output logic             global_debug_refused,
   output logic             debug_tap_blocked,
   output logic [3:0]       otp_sector_locked,
   output logic             otp_redundancy_en,
   output logic             otp_boot_forced,
   output logic             cfg_scan_denied,
   output logic             dual_issue_flag
);

   logic [31:0] security;
   logic [31:0] ring_ctrl;
   logic [31:0] dbg_status;
   logic [31:0] dbg_pc;
   logic [31:0] boot_word;
   logic [31:0] ring_word;
   logic [15:0] ring_snap [tsc_pkg::RING_COUNT];
   logic [15:0] ring_sync1 [tsc_pkg::RING_COUNT];
   logic [15:0] ring_sync2 [tsc_pkg::RING_COUNT];
   logic [15:0] ring_sel;

   // Register access arrives only on the status-instruction port
   wire wr_security = clk_en && ps_write && ps_number == tsc_pkg::REG_SECURITY;
   wire wr_ring     = clk_en && ps_write && ps_number == tsc_pkg::REG_RING_CONTROL;
   wire wr_dss      = clk_en && ps_write && debug_mode
                      && ps_number == tsc_pkg::REG_DEBUG_STATUS;
   wire wr_dpc      = clk_en && ps_write && debug_mode
                      && ps_number == tsc_pkg::REG_DEBUG_PC;
   wire sec_locked  = security[tsc_pkg::SEC_WRITE_LOCK];
   wire ring_range  = ps_number >= tsc_pkg::REG_RING_FIRST
                      && ps_number <= tsc_pkg::REG_RING_LAST;
   wire [1:0] ring_idx = 2'(ps_number - tsc_pkg::REG_RING_FIRST);

   assign boot_word = {8'h00, processor_number,
                       7'h00, boot_override,
                       2'b00, second_core_off, skip_otp_poll,
                       boot_from_ram, boot_from_tap,
                       pll_mode_strap};

   // Security loads from OTP; once bit 31 is set, writes are dropped
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         security <= 32'h0000_0000;
      end else if (clk_en && otp_load) begin
         security <= otp_security_copy & tsc_pkg::SEC_MASK;
      end else if (wr_security && !sec_locked) begin
         security <= ps_wdata & tsc_pkg::SEC_MASK;
      end
   end

   assign global_debug_refused = security[tsc_pkg::SEC_NO_GLOBAL_DBG];
   assign debug_tap_blocked    = security[tsc_pkg::SEC_NO_DEBUG_TAP];
   assign otp_sector_locked    = security[tsc_pkg::SEC_SECTOR_LSB +: 4]
                                 | {4{security[tsc_pkg::SEC_LOCK_ALL]}};
   assign otp_redundancy_en    = security[tsc_pkg::SEC_REDUNDANCY];
   assign otp_boot_forced      = security[tsc_pkg::SEC_OTP_BOOT];
   assign cfg_scan_denied      = security[tsc_pkg::SEC_NO_CFG_SCAN];

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ring_ctrl <= tsc_pkg::RING_CTRL_RESET;
      end else if (wr_ring) begin
         ring_ctrl <= ps_wdata & tsc_pkg::RING_CTRL_MASK;
      end
   end

   // Tile rings follow core enable, peripheral rings the other bit
   assign ring_enable = {{2{ring_ctrl[tsc_pkg::RING_PERIPH_EN]}},
                         {2{ring_ctrl[tsc_pkg::RING_CORE_EN]}}};

   // Counters on their own oscillator clocks with no reset at all, so counts
   // survive system reset. Reads are only meaningful once stopped, which is
   // why a plain three-stage sample of a frozen count is safe here.
   genvar g;
   generate
      for (g = 0; g < tsc_pkg::RING_COUNT; g++) begin : g_ring
         logic        en_s1;
         logic        en_s2;
         // Power-up value only; system reset never touches it
         logic [15:0] count = tsc_pkg::COUNT_INIT;
         always_ff @(posedge ring_clock[g]) begin
            en_s1 <= ring_enable[g];
            en_s2 <= en_s1;
            if (en_s2) begin
               count <= count + 16'h0001;
            end
         end
         always_ff @(posedge clock) begin
            if (clk_en) begin
               ring_sync1[g] <= count;
               ring_sync2[g] <= ring_sync1[g];
               ring_snap[g]  <= ring_sync2[g];
            end
         end
      end
   endgenerate

   // Order: tile cell, tile wire, peripheral cell, peripheral wire
   assign ring_sel  = ring_snap[ring_idx];
   assign ring_word = {16'h0000, ring_sel};

   // Debug snapshots; the debugger may also write them in debug mode
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dbg_status <= tsc_pkg::DEBUG_RESET;
         dbg_pc     <= tsc_pkg::DEBUG_RESET;
      end else if (clk_en && debug_entry) begin
         dbg_status <= saved_status_word & tsc_pkg::DSS_MASK;
         dbg_pc     <= saved_program_counter;
      end else begin
         if (wr_dss) begin
            dbg_status <= (ps_wdata & tsc_pkg::DSS_WRITE_MASK)
                          | (dbg_status & ~tsc_pkg::DSS_WRITE_MASK);
         end
         if (wr_dpc) begin
            dbg_pc <= ps_wdata;
         end
      end
   end

   assign dual_issue_flag = dbg_status[tsc_pkg::DSS_DUAL_ISSUE];

   // Read mux is combinational: value seen in the same cycle as the number
   always_comb begin
      ps_hit   = 1'b1;
      ps_rdata = 32'h0000_0000;
      case (ps_number)
         tsc_pkg::REG_BOOT_REPORT:  ps_rdata = boot_word;
         tsc_pkg::REG_SECURITY:     ps_rdata = security;
         tsc_pkg::REG_RING_CONTROL: ps_rdata = ring_ctrl;
         tsc_pkg::REG_MEMORY_SIZE:  ps_rdata = ram_size_bytes & tsc_pkg::MEM_SIZE_MASK;
         tsc_pkg::REG_DEBUG_STATUS: ps_rdata = dbg_status;
         tsc_pkg::REG_DEBUG_PC:     ps_rdata = dbg_pc;
         default: begin
            if (ring_range) begin
               ps_rdata = ring_word;
            end else begin
               ps_hit = 1'b0;
            end
         end
      endcase
   end

endmodule

// File: test/tsc_status_regs_monitor.sv
`timescale 1ns/10ps
module tsc_status_regs_monitor (
   input wire logic        clock,
   input wire logic        rst_b,
   input wire logic        clk_en,
   input wire logic        ps_write,
   input wire logic [7:0]  ps_number,
   input wire logic [31:0] ps_wdata,
   input wire logic [31:0] ps_rdata,
   input wire logic        ps_hit,
   input wire logic        otp_load,
   input wire logic [31:0] otp_security_copy,
   input wire logic [31:0] ram_size_bytes,
   input wire logic        debug_entry,
   input wire logic [31:0] saved_program_counter,
   input wire logic [3:0]  ring_enable,
   input wire logic        debug_tap_blocked,
   input wire logic [3:0]  otp_sector_locked
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire wr = clk_en && ps_write;
   sequence entry_then_pc;
      clk_en && debug_entry ##1 ps_number == 8'h11;
   endsequence
   unmapped_zero_a: assert property (!ps_hit |-> ps_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   mem_size_a: assert property (ps_number == 8'h0C |-> ps_rdata[1:0] == 2'b00
      && ps_rdata[31:2] == ram_size_bytes[31:2]) else $error("memory size wrong");
   ring_upper_a: assert property (ps_number >= 8'h07 && ps_number <= 8'h0A
      |-> ps_hit && ps_rdata[31:16] == 16'h0000) else $error("count word wrong");
   ring_enable_a: assert property (wr && ps_number == 8'h06 |=> ring_enable ==
      {{2{$past(ps_wdata[0])}}, {2{$past(ps_wdata[1])}}}) else $error("enables wrong");
   sec_lock_a: assert property (wr && ps_number == 8'h05 && ps_rdata[31] && !otp_load
      |=> $stable(otp_sector_locked) && $stable(debug_tap_blocked)) else $error("lock broken");
   otp_copy_a: assert property (clk_en && otp_load
      |=> debug_tap_blocked == $past(otp_security_copy[0])) else $error("copy not loaded");
   sector_lock_a: assert property (clk_en && otp_load |=> otp_sector_locked ==
      ($past(otp_security_copy[11:8]) | {4{$past(otp_security_copy[12])}})) else $error("sectors");
   debug_pc_a: assert property (entry_then_pc
      |-> ps_rdata == $past(saved_program_counter)) else $error("pc snapshot wrong");
endmodule
bind tsc_status_regs tsc_status_regs_monitor mon (.*);

// File: test/tile_status_config_regs_tb.sv
`timescale 1ns/10ps
module tile_status_config_regs_tb;
   logic        clock = 0, rst_b = 0, clk_en = 1, ps_write = 0, debug_mode = 0, run = 0;
   logic        boot_from_ram = 0, boot_from_tap = 0, boot_override = 0, otp_load = 0;
   logic        second_core_off = 0, skip_otp_poll = 0, debug_entry = 0, ps_hit;
   logic        global_debug_refused, debug_tap_blocked, otp_redundancy_en;
   logic        otp_boot_forced, cfg_scan_denied, dual_issue_flag;
   logic [1:0]  pll_mode_strap = '0;
   logic [3:0]  ring_clock = '0, ring_enable, otp_sector_locked;
   logic [7:0]  ps_number = '0, processor_number = '0;
   logic [31:0] ps_wdata = '0, otp_security_copy = '0, ram_size_bytes = '0, ps_rdata, s, c;
   logic [31:0] saved_status_word = '0, saved_program_counter = '0, seed = 32'h0750_e167;
   logic [31:0] cnt [4] = '{default: '0};
   int          err_count = 0, check_count = 0;
   tsc_status_regs uut (.*);
   always #50 clock = ~clock;
   // Rings stand still between runs, stepped off the core clock grid
   always #7 if (run) ring_clock = ring_clock + 4'h1;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] n, input logic [31:0] d);
      @(negedge clock);
      ps_number = n;
      ps_wdata = d;
      ps_write = 1;
      @(negedge clock);
      ps_write = 0;
   endtask
   task automatic rd(input logic [7:0] n, input logic [31:0] e);
      @(negedge clock);
      ps_number = n;
      #1 chk(ps_rdata, e);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clock);
      rst_b = 1;
      foreach (cnt[i]) rd(i < 2 ? 8'h05 + 8'(i) : 8'h0E + 8'(i), '0);
      repeat (8) begin
         s = rnd();
         {processor_number, pll_mode_strap, boot_from_ram, boot_from_tap, boot_override,
          second_core_off, skip_otp_poll} = s[14:0];
         ram_size_bytes = rnd();
         wr(8'h03, rnd());
         rd(8'h03, {8'h00, processor_number, 7'h00, boot_override, 2'b00, second_core_off,
            skip_otp_poll, boot_from_ram, boot_from_tap, pll_mode_strap});
         rd(8'h0C, {ram_size_bytes[31:2], 2'b00});
         rd(8'h04, '0);
      end
      s = rnd() & 32'h7FFF_FFFF;
      @(negedge clock);
      otp_security_copy = s;
      otp_load = 1;
      @(negedge clock);
      otp_load = 0;
      rd(8'h05, s & tsc_pkg::SEC_MASK);
      chk({global_debug_refused, debug_tap_blocked, otp_sector_locked, otp_redundancy_en,
         otp_boot_forced, cfg_scan_denied},
         {s[14], s[0], s[11:8] | {4{s[12]}}, s[7], s[5], s[4]});
      c = rnd() | 32'h8000_0000;
      wr(8'h05, c);
      rd(8'h05, c & tsc_pkg::SEC_MASK);
      wr(8'h05, ~c);
      rd(8'h05, c & tsc_pkg::SEC_MASK);
      for (int p = 0; p < 3; p++) begin
         if (p == 1) begin
            rst_b = 0;
            @(negedge clock);
            rst_b = 1;
         end else begin
            wr(8'h06, p == 0 ? 32'h0000_0003 : 32'h0000_0001);
            chk(ring_enable, p == 0 ? 4'hF : 4'hC);
            run = 1;
            repeat (20) @(negedge clock);
            wr(8'h06, '0);
            // Rings keep ticking a while so the stop reaches every counter
            repeat (3) @(negedge clock);
            run = 0;
            repeat (10) @(negedge clock);
         end
         for (int i = 0; i < 4; i++) begin
            @(negedge clock);
            ps_number = tsc_pkg::REG_RING_FIRST + 8'(i);
            #1 chk(ps_rdata[31:16], '0);
            if (p == 0) chk(ps_rdata !== cnt[i], 1'b1);
            else chk(ps_rdata === cnt[i], p == 1 || i < 2);
            cnt[i] = ps_rdata;
         end
      end
      s = rnd();
      c = rnd();
      wr(8'h10, s);
      rd(8'h10, '0);
      @(negedge clock);
      saved_status_word = s;
      saved_program_counter = c;
      ps_number = 8'h11;
      debug_entry = 1;
      @(negedge clock);
      debug_entry = 0;
      rd(8'h11, c);
      rd(8'h10, s & tsc_pkg::DSS_MASK);
      chk(dual_issue_flag, s[8]);
      debug_mode = 1;
      wr(8'h10, ~s);
      rd(8'h10, (~s & tsc_pkg::DSS_WRITE_MASK) | (s & 32'h0000_0100));
      wr(8'h11, ~c);
      rd(8'h11, ~c);
      give_verdict();
   end
endmodule
